/* File: common/nvb_pkg.sv */
// constants, state types and register map of the nv byte access controller
// assumes one 50 MHz clock shared by the core register port and the array
//
// How it works
// RQ1: software loads nv address and nv data before starting a byte update
// RQ2: write starts only after 55h, then 0AAh to unlock port, then go bit
// RQ3: software masks interrupts around the unlock steps and go bit
// RQ4: go bit cannot be set unless the program-enable latch is already set
// RQ5: enable latch and go bit set in one write never start a cycle
// RQ6: hardware never clears the program-enable latch; only writes or reset
// RQ7: software keeps the program-enable latch clear except while updating
// RQ8: control, address and data registers ignore writes during a write cycle
// RQ9: at cycle end hardware clears the go bit and sets the completion flag
// RQ10: completion flag stays set until software clears it; poll or interrupt
// RQ11: reset clears the program-enable latch
// RQ12: array writes blocked while the power-up timer runs
// RQ13: code protect disables external programmer reads and writes
// RQ14: core accesses work regardless of code protect
// RQ15: software clears both select bits before a data-array access
// RQ16: software may wait for the go bit to read clear before the next byte
// RQ17: software clears the enable latch after the completion flag is seen
// RQ18: address register is 8 bits, 256 locations 00h to FFh
// RQ19: read strobe loads addressed byte into data register next cycle
// RQ20: completion flag sits at bit 4 of peripheral request register two
// RQ21: reset during a cycle or improper attempt sets error; selects unchanged (reset here clears both select bits)
// RQ22: write duration comes from a counter whose length is a parameter
// RQ23: unlock sequencer returns to idle on any other register write

package nvb_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ      = 50;
  localparam int WR_TIME_US   = 4;
  localparam int WR_CYCLES    = WR_TIME_US * CLK_MHZ;
  localparam int PWRT_TIME_US = 72;
  localparam int PWRT_CYCLES  = PWRT_TIME_US * CLK_MHZ;
  localparam int CNT_W        = 24;

  // ****************************************
  // array geometry
  // ****************************************
  localparam int NV_ADDR_W = 8;
  localparam int NV_DATA_W = 8;
  localparam int NV_DEPTH  = 256;

  // ****************************************
  // register map
  // ****************************************
  localparam int          REG_AW     = 3;
  localparam logic [2:0] OFS_IRQ_CTL = 3'h0;
  localparam logic [2:0] OFS_ADDR    = 3'h1;
  localparam logic [2:0] OFS_DATA    = 3'h2;
  localparam logic [2:0] OFS_UNLOCK  = 3'h3;
  localparam logic [2:0] OFS_CTRL    = 3'h4;
  localparam logic [2:0] OFS_PRIO2   = 3'h5;
  localparam logic [2:0] OFS_REQ2    = 3'h6;
  localparam logic [2:0] OFS_ENA2    = 3'h7;

  localparam int CTL_PGM  = 7;
  localparam int CTL_CFG  = 6;
  localparam int CTL_FREE = 4;
  localparam int CTL_ERR  = 3;
  localparam int CTL_PEN  = 2;
  localparam int CTL_GO   = 1;
  localparam int CTL_RD   = 0;
  localparam int IRQ_DONE = 4;

  localparam logic [7:0] IRQ2_MASK = 8'hDF;
  localparam logic [7:0] BYTE_RST  = 8'h00;
  localparam logic [7:0] UNLOCK_A  = 8'h55;
  localparam logic [7:0] UNLOCK_B  = 8'hAA;

  typedef enum logic [2:0] {
    UNL_IDLE  = 3'b001,
    UNL_HALF  = 3'b010,
    UNL_ARMED = 3'b100
  } nvb_unl_t;

  typedef struct packed {
    logic [7:0]           interrupt_control;
    logic [7:0]           addr;
    logic [7:0]           data;
    logic                 pgmSel;
    logic                 cfgSel;
    logic                 free;
    logic                 err;
    logic                 pgmEn;
    logic                 go;
    logic [7:0]           prio2;
    logic [7:0]           req2;
    logic [7:0]           ena2;
    nvb_unl_t             unl;
    logic [CNT_W-1:0]     wrCnt;
    logic [CNT_W-1:0]     pwrtCnt;
    logic                 fresh;
    logic                 rdPend;
    logic                 extRdPend;
    logic [7:0]           rdData;
    logic [7:0]           extRData;
  } nvb_state_t;

endpackage : nvb_pkg

/* File: common/nvb_array_if.sv */
// link between the controller and the byte array
// assumes both ends run on sys_clk
`timescale 1ns/1ps
`default_nettype none

interface nvb_array_if;
  import nvb_pkg::*;
  logic                 en;
  logic                 we;
  logic [NV_ADDR_W-1:0] addr;
  logic [NV_DATA_W-1:0] wdata;
  logic [NV_DATA_W-1:0] rdata;
  logic                 markSet;
  logic                 markClr;
  logic                 mark;

  modport ctrl  (output en, we, addr, wdata, markSet, markClr, input rdata, mark);
  modport store (input en, we, addr, wdata, markSet, markClr, output rdata, mark);
endinterface : nvb_array_if

`default_nettype wire

/* File: logic/nvb_array.sv */
// 256-byte nonvolatile store with a registered read port
// assumes the controller never reads and writes in one cycle
`timescale 1ns/1ps
`default_nettype none

module nvb_array
  import nvb_pkg::*;
#(
  parameter int DEPTH = NV_DEPTH
) (
  input wire logic   sys_clk,
  nvb_array_if.store port
);

  logic [NV_DATA_W-1:0] cells [DEPTH];
  logic [NV_DATA_W-1:0] rdata_r;
  // in-progress mark survives rst, as the array contents do
  logic                 mark_r = 1'b0;

  always_ff @(posedge sys_clk) begin
    if (port.en && port.we) begin
      cells[port.addr] <= port.wdata;
    end
    if (port.en) begin
      rdata_r <= cells[port.addr];
    end
    if (port.markSet) begin
      mark_r <= 1'b1;
    end else if (port.markClr) begin
      mark_r <= 1'b0;
    end
  end

  assign port.rdata = rdata_r;
  assign port.mark  = mark_r;

endmodule : nvb_array

`default_nettype wire

/* File: logic/nvb_ctrl.sv */
// nv byte access controller: register file, unlock sequencer, write timer
// assumes the register master and external programmer share sys_clk
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module nvb_ctrl
  import nvb_pkg::*;
#(
  parameter int WR_CYCLES_P   = WR_CYCLES,
  parameter int PWRT_CYCLES_P = PWRT_CYCLES
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic [REG_AW-1:0]    regAddr,
  input  wire logic [7:0]           regWData,
  input  wire logic                 regWrite,
  input  wire logic                 regRead,
  output logic      [7:0]           regRData,
  input  wire logic                 codeProtect,
  input  wire logic [NV_ADDR_W-1:0] extAddr,
  input  wire logic [NV_DATA_W-1:0] extWData,
  input  wire logic                 extWrite,
  input  wire logic                 extRead,
  output logic      [NV_DATA_W-1:0] extRData,
  output logic                      nvDoneFlag,
  output logic                      nvBusy
);

  // ****************************************
  // constants
  // ****************************************
  localparam logic [CNT_W-1:0] WR_LOAD   = CNT_W'(WR_CYCLES_P - 1);
  localparam logic [CNT_W-1:0] PWRT_LOAD = CNT_W'(PWRT_CYCLES_P - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO  = '0;
  localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);

  // ****************************************
  // state and array link
  // ****************************************
  nvb_state_t  s_r;
  nvb_state_t  s_nxt;
  nvb_array_if arr ();

  nvb_array #(
    .DEPTH (NV_DEPTH)
  ) u_array (
    .sys_clk (sys_clk),
    .port    (arr)
  );

  logic       pwrtRun;
  logic       wrDone;
  logic       rdStart;
  logic       startWr;
  logic       extOk;
  logic [7:0] ctrlByte;
  logic [7:0] readMux;

  // no write may start until the power-up count reaches zero
  assign pwrtRun = (s_r.pwrtCnt != CNT_ZERO); // RQ12
  assign wrDone  = s_r.go && (s_r.wrCnt == CNT_ZERO); // RQ22

  // read strobe always reads back as zero: it clears the cycle it is taken
  assign ctrlByte = {s_r.pgmSel, s_r.cfgSel, 1'b0, s_r.free,
                     s_r.err, s_r.pgmEn, s_r.go, 1'b0};

  always_comb begin
    case (regAddr)
      OFS_IRQ_CTL: readMux = s_r.interrupt_control;
      OFS_ADDR:    readMux = s_r.addr;
      OFS_DATA:    readMux = s_r.data;
      OFS_CTRL:    readMux = ctrlByte;
      OFS_PRIO2:   readMux = s_r.prio2;
      OFS_REQ2:    readMux = s_r.req2;
      OFS_ENA2:    readMux = s_r.ena2;
      default:    readMux = BYTE_RST;
    endcase
  end

  // ****************************************
  // core read strobe and write start
  // ****************************************
  // read only with data array selected by the written select bits
  assign rdStart = regWrite && (regAddr == OFS_CTRL) && !s_r.go
                   && regWData[CTL_RD]
                   && !regWData[CTL_PGM] && !regWData[CTL_CFG]; // RQ19

  // enable must already be set from an earlier write, and sequence armed
  assign startWr = regWrite && (regAddr == OFS_CTRL) && !s_r.go
                   && regWData[CTL_GO]
                   && s_r.pgmEn // RQ4 RQ5
                   && (s_r.unl == UNL_ARMED) // RQ2
                   && !pwrtRun // RQ12
                   && !s_r.fresh;

  // external programmer gets the port only when the core leaves it idle
  assign extOk = !codeProtect // RQ13
                 && !s_r.go && !rdStart && !startWr && !s_r.fresh;

  // ****************************************
  // array port steering
  // ****************************************
  always_comb begin
    arr.en      = 1'b0;
    arr.we      = 1'b0;
    arr.addr    = s_r.addr;
    arr.wdata   = s_r.data;
    arr.markSet = startWr;
    // the mark must outlive rst so the fresh cycle after it can still see it
    arr.markClr = wrDone || (s_r.fresh && !rst);
    if (wrDone) begin
      // erase and write land together when the timer expires
      arr.en = 1'b1;
      arr.we = 1'b1;
    end else if (rdStart) begin
      arr.en   = 1'b1;
      arr.addr = s_r.addr; // RQ18
    end else if (extOk && (extWrite || extRead)) begin
      arr.addr  = extAddr;
      arr.wdata = extWData;
      arr.en    = extRead || !pwrtRun;
      arr.we    = extWrite && !pwrtRun; // RQ12
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_nxt           = s_r;
    s_nxt.rdPend    = rdStart;
    s_nxt.extRdPend = extOk && extRead && !extWrite;
    s_nxt.rdData    = regRead ? readMux : BYTE_RST;

    if (s_r.pwrtCnt != CNT_ZERO) begin
      s_nxt.pwrtCnt = s_r.pwrtCnt - CNT_ONE;
    end

    if (s_r.fresh) begin
      s_nxt.fresh = 1'b0;
    end

    if (s_r.rdPend) begin
      s_nxt.data = arr.rdata; // RQ19
    end
    if (s_r.extRdPend) begin
      s_nxt.extRData = arr.rdata; // RQ14
    end
    if (codeProtect) begin
      s_nxt.extRData = BYTE_RST; // RQ13
    end

    if (regWrite) begin
      // any write other than the expected unlock step drops the sequence
      s_nxt.unl = UNL_IDLE; // RQ23
      case (regAddr)
        OFS_IRQ_CTL: begin
          s_nxt.interrupt_control = regWData;
        end
        OFS_ADDR: begin
          if (!s_r.go) begin
            s_nxt.addr = regWData; // RQ8
          end
        end
        OFS_DATA: begin
          if (!s_r.go) begin
            s_nxt.data = regWData; // RQ8
          end
        end
        OFS_UNLOCK: begin
          if ((s_r.unl == UNL_IDLE) && (regWData == UNLOCK_A)) begin
            s_nxt.unl = UNL_HALF; // RQ2
          end else if ((s_r.unl == UNL_HALF) && (regWData == UNLOCK_B)) begin
            s_nxt.unl = UNL_ARMED; // RQ2
          end else if (regWData == UNLOCK_A) begin
            s_nxt.unl = UNL_HALF;
          end
        end
        OFS_CTRL: begin
          if (!s_r.go) begin // RQ8
            s_nxt.pgmSel = regWData[CTL_PGM];
            s_nxt.cfgSel = regWData[CTL_CFG];
            s_nxt.free   = regWData[CTL_FREE];
            s_nxt.err    = regWData[CTL_ERR];
            s_nxt.pgmEn  = regWData[CTL_PEN]; // RQ6
            if (startWr) begin
              s_nxt.go    = 1'b1;
              s_nxt.err   = 1'b1;
              s_nxt.wrCnt = WR_LOAD; // RQ22
            end else if (regWData[CTL_GO] && s_r.pgmEn) begin
              // improper attempt: selects keep their old values
              s_nxt.err    = 1'b1; // RQ21
              s_nxt.pgmSel = s_r.pgmSel;
              s_nxt.cfgSel = s_r.cfgSel;
            end
          end
        end
        OFS_PRIO2: begin
          s_nxt.prio2 = regWData & IRQ2_MASK;
        end
        OFS_REQ2: begin
          s_nxt.req2 = regWData & IRQ2_MASK; // RQ10
        end
        OFS_ENA2: begin
          s_nxt.ena2 = regWData & IRQ2_MASK;
        end
        default: begin
        end
      endcase
    end

    // write timer; go stays up for the whole count
    if (s_r.go) begin
      if (wrDone) begin
        s_nxt.go  = 1'b0; // RQ9
        s_nxt.err = 1'b0;
      end else begin
        s_nxt.wrCnt = s_r.wrCnt - CNT_ONE; // RQ22
      end
    end

    // hardware set wins over a software clear in the same cycle
    if (wrDone) begin
      s_nxt.req2[IRQ_DONE] = 1'b1; // RQ9 RQ10 RQ20
    end

    // a write cut short by reset leaves its mark in the array; this set
    // wins over a control write landing in the same fresh cycle
    if (s_r.fresh && arr.mark) begin
      s_nxt.err = 1'b1; // RQ21
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_r           <= '0;
      s_r.pgmEn     <= 1'b0; // RQ11
      s_r.unl       <= UNL_IDLE;
      s_r.pwrtCnt   <= PWRT_LOAD; // RQ12
      s_r.fresh     <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign regRData   = s_r.rdData;
  assign extRData   = s_r.extRData;
  assign nvDoneFlag = s_r.req2[IRQ_DONE];
  assign nvBusy     = s_r.go;

endmodule : nvb_ctrl

`default_nettype wire

/* File: verification/nvb_ctrl_properties.sv */
// timing checks on the nv byte access controller ports
// assumes one clock and an active-high asynchronous reset
`timescale 1ns/1ps
`default_nettype none

module nvb_ctrl_properties
  import nvb_pkg::*;
#(
  parameter int WR_CYCLES_P = WR_CYCLES
) (
  input wire logic              sys_clk,
  input wire logic              rst,
  input wire logic [REG_AW-1:0] regAddr,
  input wire logic [7:0]        regWData,
  input wire logic              regWrite,
  input wire logic              regRead,
  input wire logic [7:0]        regRData,
  input wire logic              codeProtect,
  input wire logic [7:0]        extRData,
  input wire logic              nvDoneFlag,
  input wire logic              nvBusy
);
  // ****************************************
  // busy length counter
  // ****************************************
  logic [CNT_W-1:0] busyLen_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busyLen_r <= '0;
    end else begin
      busyLen_r <= nvBusy ? busyLen_r + 1'b1 : '0;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ****************************************
  // properties
  // ****************************************
  AST_READ_SLOT: assert property (regRData != 8'h00 |-> $past(regRead))
    else $error("read data outside its slot");
  AST_BUSY_LEN: assert property ($fell(nvBusy) |-> busyLen_r == CNT_W'(WR_CYCLES_P))
    else $error("write cycle length wrong");
  AST_BUSY_MAX: assert property (busyLen_r <= CNT_W'(WR_CYCLES_P))
    else $error("write cycle too long");
  AST_GO_CAUSE: assert property ($rose(nvBusy) |-> $past(regWrite) &&
    $past(regAddr) == OFS_CTRL && $past(regWData[CTL_GO]))
    else $error("cycle started without a go write");
  AST_DONE_AT_END: assert property ($fell(nvBusy) |-> nvDoneFlag)
    else $error("completion flag missing at cycle end");
  AST_DONE_SOURCE: assert property ($rose(nvDoneFlag) |-> $fell(nvBusy) ||
    ($past(regWrite) && $past(regAddr) == OFS_REQ2))
    else $error("completion flag set without completion");
  AST_DONE_STICKY: assert property ($fell(nvDoneFlag) |-> $past(regWrite) &&
    $past(regAddr) == OFS_REQ2 && !$past(regWData[IRQ_DONE]))
    else $error("completion flag cleared without software");
  AST_PROTECT_ZERO: assert property ($past(codeProtect) && $past(codeProtect, 2)
    |-> extRData == 8'h00)
    else $error("external read data visible under protection");
endmodule : nvb_ctrl_properties

bind nvb_ctrl nvb_ctrl_properties #(.WR_CYCLES_P(WR_CYCLES_P)) i_props (
  .sys_clk(sys_clk),
  .rst(rst),
  .regAddr(regAddr),
  .regWData(regWData),
  .regWrite(regWrite),
  .regRead(regRead),
  .regRData(regRData),
  .codeProtect(codeProtect),
  .extRData(extRData),
  .nvDoneFlag(nvDoneFlag),
  .nvBusy(nvBusy)
);

`default_nettype wire

/* File: verification/test_nvb_ctrl.sv */
// self-checking bench for the nv byte access controller
// assumes short write and power-up counts set through parameters
`timescale 1ns/1ps
`default_nettype none

module test_nvb_ctrl;
  import nvb_pkg::*;
  localparam int WRC = 5;
  localparam int PWC = 40;

  logic              sys_clk, rst, regWrite, regRead, codeProtect, extWrite, extRead;
  logic [REG_AW-1:0] regAddr;
  logic [7:0]        regWData, regRData, extAddr, extWData, extRData, nvA, nvD;
  logic              nvDoneFlag, nvBusy;
  logic              rdPend = 1'b0;
  logic [31:0]       rnd;
  logic [7:0]        expQ[$];
  int                fails, num_checks, seed, i;

  nvb_ctrl #(.WR_CYCLES_P(WRC), .PWRT_CYCLES_P(PWC)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWData(regWData),
    .regWrite(regWrite), .regRead(regRead), .regRData(regRData),
    .codeProtect(codeProtect), .extAddr(extAddr), .extWData(extWData),
    .extWrite(extWrite), .extRead(extRead), .extRData(extRData),
    .nvDoneFlag(nvDoneFlag), .nvBusy(nvBusy));

  // ****************************************
  // checking
  // ****************************************
  task automatic chk(input logic [7:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test

  // read data stands only in the cycle after the strobe
  always @(posedge sys_clk) begin
    if (rdPend === 1'b1) chk(regRData, expQ.pop_front());
    rdPend <= regRead;
  end

  // ****************************************
  // drivers
  // ****************************************
  task automatic op(input logic w, r, input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrite <= w;
    regRead  <= r;
    regAddr  <= a;
    regWData <= d;
    extWrite <= 1'b0;
    extRead  <= 1'b0;
  endtask : op

  task automatic ext(input logic w, r, input logic [7:0] a, d);
    @(posedge sys_clk);
    regWrite <= 1'b0;
    regRead  <= 1'b0;
    extWrite <= w;
    extRead  <= r;
    extAddr  <= a;
    extWData <= d;
  endtask : ext

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    op(1'b1, 1'b0, a, d);
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    expQ.push_back(e);
    op(1'b0, 1'b1, a, 8'h00);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) op(1'b0, 1'b0, 3'h0, 8'h00);
  endtask : idle

  task automatic cb(input logic b, f);
    @(negedge sys_clk);
    chk({6'h00, nvBusy, nvDoneFlag}, {6'h00, b, f});
  endtask : cb

  task automatic waitIdle();
    for (int k = 0; k < 50; k++) begin
      idle(1);
      @(negedge sys_clk);
      if (nvBusy === 1'b0) break;
    end
  endtask : waitIdle

  task automatic unlockGo(input logic [2:0] midA, input logic [7:0] ctl);
    wr(OFS_UNLOCK, UNLOCK_A);
    if (midA != OFS_UNLOCK) wr(midA, 8'h5A);
    wr(OFS_UNLOCK, UNLOCK_B);
    wr(OFS_CTRL, ctl);
  endtask : unlockGo

  task automatic wrByte(input logic [7:0] a, d);
    wr(OFS_ADDR, a);
    wr(OFS_DATA, d);
    wr(OFS_CTRL, 8'h04);
    wr(OFS_IRQ_CTL, 8'h00);
    unlockGo(OFS_UNLOCK, 8'h06);
    idle(2);
    cb(1'b1, 1'b0);
    wr(OFS_DATA, ~d);
    wr(OFS_CTRL, 8'h00);
    rd(OFS_CTRL, 8'h0E);
    waitIdle();
    cb(1'b0, 1'b1);
    rd(OFS_CTRL, 8'h04);
    wr(OFS_CTRL, 8'h00);
    rd(OFS_REQ2, 8'h10);
    idle(8);
    rd(OFS_REQ2, 8'h10);
    wr(OFS_REQ2, 8'h00);
    rd(OFS_REQ2, 8'h00);
  endtask : wrByte

  task automatic arrRd(input logic [7:0] a, d);
    wr(OFS_ADDR, a);
    wr(OFS_DATA, ~d);
    wr(OFS_CTRL, 8'h01);
    idle(2);
    rd(OFS_DATA, d);
  endtask : arrRd

  // ****************************************
  // clock, watchdog, sequence
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    finish_test();
  end

  initial begin
    seed = 32'hB6776AC2;
    {rst, regWrite, regRead, codeProtect, extWrite, extRead} = 6'h20;
    {regAddr, regWData, extAddr, extWData} = '0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    for (i = 0; i < 8; i++) rd(i[2:0], 8'h00);
    wr(OFS_CTRL, 8'h04);
    unlockGo(OFS_UNLOCK, 8'h06);
    idle(3);
    cb(1'b0, 1'b0);
    wr(OFS_CTRL, 8'h00);
    idle(PWC);
    wr(OFS_IRQ_CTL, 8'hA5);
    wr(OFS_PRIO2, 8'hFF);
    wr(OFS_ENA2, 8'hFF);
    rd(OFS_IRQ_CTL, 8'hA5);
    rd(OFS_PRIO2, 8'hDF);
    rd(OFS_ENA2, 8'hDF);
    rd(OFS_UNLOCK, 8'h00);
    // go beside the enable latch in one write must not start
    unlockGo(OFS_UNLOCK, 8'h06);
    idle(2);
    cb(1'b0, 1'b0);
    rd(OFS_CTRL, 8'h04);
    wr(OFS_CTRL, 8'h06);
    idle(2);
    cb(1'b0, 1'b0);
    rd(OFS_CTRL, 8'h0C);
    wr(OFS_CTRL, 8'hD4);
    unlockGo(OFS_IRQ_CTL, 8'hD6);
    idle(2);
    cb(1'b0, 1'b0);
    rd(OFS_CTRL, 8'hDC);
    wr(OFS_CTRL, 8'h00);
    for (i = 0; i < 2; i++) begin
      rnd = $random(seed);
      nvA = (i == 0) ? 8'hFF : rnd[7:0];
      nvD = rnd[15:8];
      wrByte(nvA, nvD);
      arrRd(nvA, nvD);
    end
    codeProtect <= 1'b1;
    ext(1'b1, 1'b0, nvA, ~nvD);
    ext(1'b0, 1'b1, nvA, 8'h00);
    idle(3);
    @(negedge sys_clk) chk(extRData, 8'h00);
    arrRd(nvA, nvD);
    codeProtect <= 1'b0;
    ext(1'b1, 1'b0, nvA, 8'h3C);
    ext(1'b0, 1'b1, nvA, 8'h00);
    idle(3);
    @(negedge sys_clk) chk(extRData, 8'h3C);
    // reset in the middle of a write leaves the error bit behind
    wr(OFS_CTRL, 8'h04);
    unlockGo(OFS_UNLOCK, 8'h06);
    idle(3);
    cb(1'b1, 1'b0);
    @(posedge sys_clk) rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd(OFS_CTRL, 8'h08);
    idle(3);
    finish_test();
  end
endmodule : test_nvb_ctrl

`default_nettype wire
